//--- design/pms_pkg.sv
// package for the power-mode sequencer: field positions, reset values, states and carriers
// assumes a single 40 MHz system clock and one synchronous active-high reset
package pms_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int NUM_WAKE_PINS = 8;
    localparam int NUM_IRQ = 8;

    // ****************************************
    // clock control register layout
    // ****************************************
    localparam int CKS_MSB = 7;
    localparam int CKS_LSB = 5;
    localparam int HI_KEEP_BIT = 1;
    localparam int LO_KEEP_BIT = 0;
    localparam logic [7:0] SCC_RESET = 8'h00;
    localparam logic [7:0] SCC_WRITE_MASK = 8'hE3;
    localparam logic [2:0] CKS_SUB = 3'h7;

    // ****************************************
    // timing
    // ****************************************
    localparam int DIV_W = 6;
    localparam logic [DIV_W-1:0] DIV_ZERO = 6'h00;

    typedef enum logic [2:0] {
        ST_FAST,
        ST_TO_SLOW,
        ST_SLOW,
        ST_TO_FAST,
        ST_HALTED,
        ST_WAKE_WAIT
    } seq_state_e;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_IDLE_SUB_ONLY,
        MODE_IDLE_FAST_ONLY,
        MODE_IDLE_BOTH_OSC
    } low_mode_e;

    typedef enum logic [1:0] {
        WAKE_NONE,
        WAKE_PIN,
        WAKE_IRQ,
        WAKE_WDT
    } wake_src_e;

    // answer to the cpu when it may run again
    typedef struct packed {
        logic resume;
        logic vector;
        logic pc_sp_reset;
    } resume_s;

    // clock gating outputs
    typedef struct packed {
        logic sys_clk_en;
        logic fast_clk_run;
        logic sub_clk_run;
        logic cpu_run;
    } clk_gate_s;

endpackage

//--- design/pms_clk_div.sv
// system clock enable divider: one-cycle pulse every 2^sel cycles of fast_clock ticks (64 for sel 7)
// assumes fast_tick is an in-domain enable marking each fast_clock period
`timescale 1ns/100ps
`default_nettype none
module pms_clk_div (
    input wire logic clk,
    input wire logic reset,
    input wire logic fast_tick,
    input wire logic [2:0] sel,
    output logic sys_tick
);
    import pms_pkg::*;

    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic [DIV_W-1:0] mask;

    always_comb begin
        mask = DIV_W'((7'h01 << sel) - 7'h01);
        nxt_cnt = cnt_ff;
        if (fast_tick) begin
            nxt_cnt = DIV_W'(cnt_ff + 6'h01) & mask;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_ff <= DIV_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // counter wraps under the mask, so a divide change takes effect within one period
    assign sys_tick = fast_tick && ((cnt_ff & mask) == DIV_ZERO);
endmodule
`default_nettype wire

//--- design/power_mode_sequencer.sv
// power-mode sequencer: fast/slow clock select, halt into sleep or idle, wake-up and resume
// assumes cpu, interrupt controller and oscillators share clk; pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
module power_mode_sequencer (
    input wire logic clk,
    input wire logic reset,
    input wire logic scc_wr,
    input wire logic [7:0] scc_wdata,
    output logic [7:0] system_clock_control_reg,
    input wire logic hi_osc_enable,
    input wire logic hi_osc_ready,
    input wire logic lo_osc_ready,
    output logic hi_osc_stable_flag,
    input wire logic fast_tick,
    input wire logic halt_req,
    input wire logic clr_wdt,
    input wire logic stack_full,
    input wire logic [pms_pkg::NUM_IRQ-1:0] irq_req,
    input wire logic [pms_pkg::NUM_IRQ-1:0] irq_enable,
    input wire logic wdt_overflow,
    input wire logic [pms_pkg::NUM_WAKE_PINS-1:0] porta_pin,
    input wire logic [pms_pkg::NUM_WAKE_PINS-1:0] porta_wake_enable,
    output logic powered_down_flag,
    output logic watchdog_expiry_flag,
    output logic wdt_clear,
    output pms_pkg::resume_s resume_out,
    output pms_pkg::clk_gate_s clk_gate,
    output logic sys_tick,
    output logic slow_active
);
    import pms_pkg::*;

    // ****************************************
    // pin synchronisers and edge detect
    // ****************************************
    logic [NUM_WAKE_PINS-1:0] pa_s1_ff, pa_s2_ff, pa_d_ff;
    logic [NUM_WAKE_PINS-1:0] nxt_pa_s1, nxt_pa_s2, nxt_pa_d;
    logic [NUM_WAKE_PINS-1:0] pa_fall;

    always_comb begin
        nxt_pa_s1 = porta_pin;
        nxt_pa_s2 = pa_s1_ff;
        nxt_pa_d = pa_s2_ff;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            pa_s1_ff <= 8'hFF;
            pa_s2_ff <= 8'hFF;
            pa_d_ff <= 8'hFF;
        end else begin
            pa_s1_ff <= nxt_pa_s1;
            pa_s2_ff <= nxt_pa_s2;
            pa_d_ff <= nxt_pa_d;
        end
    end
    // each pin gated by its own enable
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WAKE_PINS; gi++) begin : g_pin
            assign pa_fall[gi] = porta_wake_enable[gi] && pa_d_ff[gi] && !pa_s2_ff[gi];
        end
    endgenerate

    // ****************************************
    // clock control register and oscillator flag
    // ****************************************
    logic [7:0] scc_ff, nxt_scc;
    logic hstab_ff, nxt_hstab;
    logic hen_d_ff, nxt_hen_d;

    always_comb begin
        nxt_scc = scc_ff;
        if (scc_wr) begin
            nxt_scc = scc_wdata & SCC_WRITE_MASK;
        end
        nxt_hen_d = hi_osc_enable;
        nxt_hstab = hstab_ff;
        // a gated oscillator loses its settle, so a wake must see it stable afresh
        if (!hi_osc_enable || !clk_gate.fast_clk_run) begin
            nxt_hstab = 1'b0;
        end else if (!hen_d_ff) begin
            nxt_hstab = 1'b0;
        end else if (hi_osc_ready) begin
            nxt_hstab = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            scc_ff <= SCC_RESET;
            hstab_ff <= 1'b0;
            hen_d_ff <= 1'b0;
        end else begin
            scc_ff <= nxt_scc;
            hstab_ff <= nxt_hstab;
            hen_d_ff <= nxt_hen_d;
        end
    end

    assign system_clock_control_reg = scc_ff;
    assign hi_osc_stable_flag = hstab_ff;
    logic [2:0] cks;
    logic hi_keep, lo_keep;
    assign cks = scc_ff[CKS_MSB:CKS_LSB];
    assign hi_keep = scc_ff[HI_KEEP_BIT];
    assign lo_keep = scc_ff[LO_KEEP_BIT];

    // ****************************************
    // sequencer
    // ****************************************
    seq_state_e st_ff, nxt_st;
    seq_state_e ret_ff, nxt_ret;
    low_mode_e mode_ff, nxt_mode;
    logic pdf_ff, nxt_pdf;
    logic to_ff, nxt_to;
    logic [NUM_IRQ-1:0] armed_ff, nxt_armed;
    resume_s res_ff, nxt_res;
    logic wclr_ff, nxt_wclr;
    wake_src_e src_ff, nxt_src;
    logic [NUM_IRQ-1:0] irq_wake;
    logic any_wake, orig_stable;
    // an interrupt already pending at halt entry stays disarmed
    assign irq_wake = irq_req & armed_ff;
    assign any_wake = (|pa_fall) || (|irq_wake) || wdt_overflow;
    // slow returns to the sub clock, fast to the high oscillator
    assign orig_stable = (ret_ff == ST_SLOW) ? lo_osc_ready : hstab_ff;
    always_comb begin
        nxt_st = st_ff;
        nxt_ret = ret_ff;
        nxt_mode = mode_ff;
        nxt_pdf = pdf_ff;
        nxt_to = to_ff;
        nxt_armed = armed_ff;
        nxt_res = '0;
        nxt_wclr = 1'b0;
        nxt_src = src_ff;
        if (clr_wdt) begin
            nxt_pdf = 1'b0;
        end
        case (st_ff)
            ST_FAST: begin
                if (halt_req) begin
                    nxt_st = ST_HALTED;
                    nxt_ret = ST_FAST;
                end else if (cks == CKS_SUB) begin
                    nxt_st = ST_TO_SLOW;
                end
            end
            ST_TO_SLOW: begin
                if (cks != CKS_SUB) begin
                    nxt_st = ST_FAST;
                end else if (lo_osc_ready) begin
                    nxt_st = ST_SLOW;
                end
            end
            ST_SLOW: begin
                if (halt_req) begin
                    nxt_st = ST_HALTED;
                    nxt_ret = ST_SLOW;
                end else if (cks != CKS_SUB) begin
                    nxt_st = ST_TO_FAST;
                end
            end
            ST_TO_FAST: begin
                if (cks == CKS_SUB) begin
                    nxt_st = ST_SLOW;
                end else if (hstab_ff) begin
                    nxt_st = ST_FAST;
                end
            end
            ST_HALTED: begin
                if (any_wake) begin
                    nxt_st = ST_WAKE_WAIT;
                    if (wdt_overflow) begin
                        nxt_src = WAKE_WDT;
                        nxt_to = 1'b1;
                    end else if (|pa_fall) begin
                        nxt_src = WAKE_PIN;
                    end else begin
                        nxt_src = WAKE_IRQ;
                    end
                end
            end
            ST_WAKE_WAIT: begin
                if (orig_stable) begin
                    nxt_st = ret_ff;
                    nxt_res.resume = 1'b1;
                    nxt_res.pc_sp_reset = (src_ff == WAKE_WDT);
                    // vector only on an interrupt wake when any request is both pending and enabled and a stack level is free
                    nxt_res.vector = (src_ff == WAKE_IRQ) && !stack_full
                        && |(irq_req & irq_enable);
                end
            end
            default: begin
                nxt_st = ST_FAST;
            end
        endcase
        if (st_ff != ST_HALTED && nxt_st == ST_HALTED) begin
            nxt_mode = low_mode_e'({hi_keep, lo_keep});
            nxt_pdf = 1'b1;
            nxt_to = 1'b0;
            nxt_wclr = 1'b1;
            nxt_armed = ~irq_req;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= ST_FAST;
            ret_ff <= ST_FAST;
            mode_ff <= MODE_SLEEP;
            pdf_ff <= 1'b0;
            to_ff <= 1'b0;
            armed_ff <= '0;
            res_ff <= '0;
            wclr_ff <= 1'b0;
            src_ff <= WAKE_NONE;
        end else begin
            st_ff <= nxt_st;
            ret_ff <= nxt_ret;
            mode_ff <= nxt_mode;
            pdf_ff <= nxt_pdf;
            to_ff <= nxt_to;
            armed_ff <= nxt_armed;
            res_ff <= nxt_res;
            wclr_ff <= nxt_wclr;
            src_ff <= nxt_src;
        end
    end

    assign powered_down_flag = pdf_ff;
    assign watchdog_expiry_flag = to_ff;
    assign wdt_clear = wclr_ff;
    assign resume_out = res_ff;
    assign slow_active = (st_ff == ST_SLOW) || (st_ff == ST_TO_FAST);

    // ****************************************
    // clock gating
    // ****************************************
    logic fast_tick_div;
    logic halted;
    assign halted = (st_ff == ST_HALTED) || (st_ff == ST_WAKE_WAIT);
    pms_clk_div u_div (
        .clk(clk),
        .reset(reset),
        .fast_tick(fast_tick),
        .sel(cks),
        .sys_tick(fast_tick_div)
    );
    always_comb begin
        clk_gate.cpu_run = !halted;
        clk_gate.sys_clk_en = !halted;
        clk_gate.fast_clk_run = 1'b1;
        clk_gate.sub_clk_run = 1'b1;
        if (st_ff == ST_HALTED) begin
            clk_gate.fast_clk_run = (mode_ff == MODE_IDLE_BOTH_OSC)
                || (mode_ff == MODE_IDLE_FAST_ONLY);
            clk_gate.sub_clk_run = (mode_ff == MODE_IDLE_BOTH_OSC)
                || (mode_ff == MODE_IDLE_SUB_ONLY);
        end
    end

    // sub clock path ticks every cycle here; the real sub rate lives outside
    assign sys_tick = halted ? 1'b0 : (slow_active ? 1'b1 : fast_tick_div);

    // ****************************************
    // checks
    // ****************************************
    property p_entry_flags;
        @(posedge clk) disable iff (reset)
        (st_ff != ST_HALTED && nxt_st == ST_HALTED) |=> pdf_ff && !to_ff && wdt_clear;
    endproperty
    a_entry_flags: assert property (p_entry_flags) else $error("entry flags wrong");
    property p_wdt_clear;
        @(posedge clk) disable iff (reset)
        $rose(st_ff == ST_HALTED) |-> wdt_clear ##1 !wdt_clear;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("wdt clear missing");
    property p_clr_pdf;
        @(posedge clk) disable iff (reset)
        (clr_wdt && !(st_ff != ST_HALTED && nxt_st == ST_HALTED)) |=> !pdf_ff;
    endproperty
    a_clr_pdf: assert property (p_clr_pdf) else $error("pdf not cleared");
    property p_sleep_clocks;
        @(posedge clk) disable iff (reset)
        (st_ff == ST_HALTED && mode_ff == MODE_SLEEP) |-> !clk_gate.fast_clk_run
            && !clk_gate.sub_clk_run && !clk_gate.cpu_run;
    endproperty
    a_sleep_clocks: assert property (p_sleep_clocks) else $error("sleep clocks on");
    property p_slow_wait;
        @(posedge clk) disable iff (reset)
        (st_ff == ST_TO_SLOW && !lo_osc_ready) |=> st_ff != ST_SLOW;
    endproperty
    a_slow_wait: assert property (p_slow_wait) else $error("slow too early");
    property p_fast_wait;
        @(posedge clk) disable iff (reset)
        (st_ff == ST_TO_FAST && !hstab_ff) |=> st_ff != ST_FAST;
    endproperty
    a_fast_wait: assert property (p_fast_wait) else $error("fast too early");
    property p_wdt_wake;
        @(posedge clk) disable iff (reset)
        (st_ff == ST_HALTED && wdt_overflow) |=> to_ff && st_ff == ST_WAKE_WAIT;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake wrong");
    property p_resume_stable;
        @(posedge clk) disable iff (reset)
        resume_out.resume |-> $past(st_ff) == ST_WAKE_WAIT && $past(orig_stable);
    endproperty
    a_resume_stable: assert property (p_resume_stable) else $error("resume unstable");

    c_sleep: cover property (@(posedge clk) st_ff == ST_HALTED && mode_ff == MODE_SLEEP);
    c_slow: cover property (@(posedge clk) st_ff == ST_SLOW);
    c_vector: cover property (@(posedge clk) resume_out.vector);
    c_wdt: cover property (@(posedge clk) resume_out.pc_sp_reset);
endmodule
`default_nettype wire

//--- tb/pms_osc_model.sv
// oscillator side model: high and low speed ready flags and the fast clock tick enable
// assumes one clk domain; the high oscillator restarts only while its clock is let run
`timescale 1ns/100ps
`default_nettype none
module pms_osc_model #(
    parameter int HI_DLY = 6,
    parameter int LO_DLY = 30
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic hi_osc_enable,
    input wire logic fast_clk_run,
    output logic hi_osc_ready,
    output logic lo_osc_ready,
    output logic fast_tick
);
    // ****************************************
    // settle counters
    // ****************************************
    logic [7:0] hi_cnt_ff;
    logic [7:0] lo_cnt_ff;
    logic tick_ff;
    // a stopped oscillator loses its settle count, so every restart pays the full delay
    always_ff @(posedge clk) begin
        if (reset) begin
            hi_cnt_ff <= 8'h00;
            lo_cnt_ff <= 8'h00;
            tick_ff <= 1'h0;
        end else begin
            tick_ff <= ~tick_ff;
            if (!hi_osc_enable || !fast_clk_run) begin
                hi_cnt_ff <= 8'h00;
            end else if (hi_cnt_ff < 8'(HI_DLY)) begin
                hi_cnt_ff <= hi_cnt_ff + 8'h01;
            end
            if (lo_cnt_ff < 8'(LO_DLY)) begin
                lo_cnt_ff <= lo_cnt_ff + 8'h01;
            end
        end
    end
    assign hi_osc_ready = hi_osc_enable && fast_clk_run && (hi_cnt_ff >= 8'(HI_DLY));
    assign lo_osc_ready = lo_cnt_ff >= 8'(LO_DLY);
    // fast clock period is two clk cycles and the tick stops while fast_clk_run is low, not with hi_osc_enable
    assign fast_tick = tick_ff & fast_clk_run;
endmodule
`default_nettype wire

//--- tb/power_mode_sequencer_tb.sv
// testbench for the power-mode sequencer: table loops for dividers and halt modes, then wakes
// assumes the oscillator model drives ready flags and fast ticks; inputs change at negedge
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module power_mode_sequencer_tb;
    import pms_pkg::*;
    localparam int HI_DLY = 6;
    typedef struct {logic [2:0] sel; int period;} div_row_s;
    typedef struct {logic [1:0] keep; logic fast_run; logic sub_run;} halt_row_s;
    logic clk, reset, scc_wr, hi_osc_enable, hi_osc_ready, lo_osc_ready, fast_tick;
    logic halt_req, clr_wdt, stack_full, wdt_overflow, hi_osc_stable_flag;
    logic powered_down_flag, watchdog_expiry_flag, wdt_clear, sys_tick, slow_active;
    logic [7:0] scc_wdata, system_clock_control_reg;
    logic [NUM_IRQ-1:0] irq_req, irq_enable;
    logic [NUM_WAKE_PINS-1:0] porta_pin, porta_wake_enable;
    resume_s resume_out;
    clk_gate_s clk_gate;
    int fail_count, n_checks, cyc;
    // fast tick is every second clk, so divide by 2^sel gives 2^(sel+1) clk cycles
    div_row_s div_rows[7] = '{'{3'h0, 2}, '{3'h1, 4}, '{3'h2, 8}, '{3'h3, 16},
                              '{3'h4, 32}, '{3'h5, 64}, '{3'h6, 128}};
    halt_row_s halt_rows[4] = '{'{2'h0, 1'h0, 1'h0}, '{2'h1, 1'h0, 1'h1},
                                '{2'h3, 1'h1, 1'h1}, '{2'h2, 1'h1, 1'h0}};

    power_mode_sequencer dut (.clk(clk), .reset(reset), .scc_wr(scc_wr), .scc_wdata(scc_wdata),
        .system_clock_control_reg(system_clock_control_reg), .hi_osc_enable(hi_osc_enable),
        .hi_osc_ready(hi_osc_ready), .lo_osc_ready(lo_osc_ready),
        .hi_osc_stable_flag(hi_osc_stable_flag), .fast_tick(fast_tick), .halt_req(halt_req),
        .clr_wdt(clr_wdt), .stack_full(stack_full), .irq_req(irq_req), .irq_enable(irq_enable),
        .wdt_overflow(wdt_overflow), .porta_pin(porta_pin),
        .porta_wake_enable(porta_wake_enable), .powered_down_flag(powered_down_flag),
        .watchdog_expiry_flag(watchdog_expiry_flag), .wdt_clear(wdt_clear),
        .resume_out(resume_out), .clk_gate(clk_gate), .sys_tick(sys_tick),
        .slow_active(slow_active));
    pms_osc_model #(.HI_DLY(HI_DLY), .LO_DLY(30)) osc (.clk(clk), .reset(reset),
        .hi_osc_enable(hi_osc_enable), .fast_clk_run(clk_gate.fast_clk_run),
        .hi_osc_ready(hi_osc_ready), .lo_osc_ready(lo_osc_ready), .fast_tick(fast_tick));

    // ****************************************
    // bench tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic write_scc(input logic [7:0] d);
        scc_wr = 1'h1;
        scc_wdata = d;
        tick(1);
        scc_wr = 1'h0;
    endtask
    task automatic halt();
        halt_req = 1'h1;
        tick(1);
        halt_req = 1'h0;
    endtask
    task automatic wait_slow(input logic v);
        cyc = 0;
        while (slow_active !== v && cyc < 80) begin
            tick(1);
            cyc++;
        end
    endtask
    // resume is a one-cycle pulse, so it is looked for at every falling edge
    task automatic wait_resume(input int lim);
        cyc = 0;
        while (resume_out.resume !== 1'h1 && cyc < lim) begin
            tick(1);
            cyc++;
        end
        `CHECK(resume_out.resume, 1'h1)
    endtask
    task automatic expect_asleep(input int n);
        repeat (n) begin
            tick(1);
            `CHECK(clk_gate.cpu_run, 1'h0)
            `CHECK(resume_out.resume, 1'h0)
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("watchdog expired");
        complete_run();
    end
    initial begin
        fail_count = 0;
        n_checks = 0;
        reset = 1'h1;
        {scc_wr, halt_req, clr_wdt, stack_full, wdt_overflow} = 5'h00;
        scc_wdata = 8'h00;
        hi_osc_enable = 1'h1;
        irq_req = 8'h00;
        irq_enable = 8'h00;
        porta_pin = 8'hFF;
        porta_wake_enable = 8'h00;
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHECK(system_clock_control_reg, 8'h00)
        `CHECK({powered_down_flag, watchdog_expiry_flag}, 2'h0)
        `CHECK(clk_gate.cpu_run, 1'h1)
        reset = 1'h0;
        write_scc(8'hFC);
        `CHECK(system_clock_control_reg, 8'hE0)
        tick(8);
        `CHECK(slow_active, 1'h0)
        wait_slow(1'h1);
        `CHECK(slow_active, 1'h1)
        `CHECK(sys_tick, 1'h1)
        hi_osc_enable = 1'h0;
        tick(3);
        `CHECK(hi_osc_stable_flag, 1'h0)
        write_scc(8'h00);
        tick(5);
        `CHECK(slow_active, 1'h1)
        hi_osc_enable = 1'h1;
        tick(1);
        `CHECK(hi_osc_stable_flag, 1'h0)
        wait_slow(1'h0);
        `CHECK(slow_active, 1'h0)
        `CHECK(hi_osc_stable_flag, 1'h1)
        $display("test slow and back done");
        foreach (div_rows[i]) begin
            write_scc({div_rows[i].sel, 5'h1F});
            `CHECK(system_clock_control_reg, {div_rows[i].sel, 5'h03})
            tick(4);
            cyc = 0;
            while (sys_tick !== 1'h1 && cyc < 300) begin
                tick(1);
                cyc++;
            end
            cyc = 0;
            do begin
                tick(1);
                cyc++;
            end while (sys_tick !== 1'h1 && cyc < 300);
            `CHECK(cyc, div_rows[i].period)
        end
        $display("test divider table done");
        foreach (halt_rows[i]) begin
            write_scc({6'h00, halt_rows[i].keep});
            halt();
            `CHECK(powered_down_flag, 1'h1)
            `CHECK(watchdog_expiry_flag, 1'h0)
            `CHECK(wdt_clear, 1'h1)
            `CHECK(clk_gate.fast_clk_run, halt_rows[i].fast_run)
            `CHECK(clk_gate.sub_clk_run, halt_rows[i].sub_run)
            if (halt_rows[i].keep == 2'h0) `CHECK(clk_gate.sys_clk_en, 1'h0)
            expect_asleep(4);
            wdt_overflow = 1'h1;
            tick(1);
            wdt_overflow = 1'h0;
            `CHECK(watchdog_expiry_flag, 1'h1)
            wait_resume(60);
            `CHECK(resume_out.pc_sp_reset, 1'h1)
            `CHECK(powered_down_flag, 1'h1)
            if (!halt_rows[i].fast_run) `CHECK(cyc >= HI_DLY, 1'h1)
            clr_wdt = 1'h1;
            tick(1);
            clr_wdt = 1'h0;
            `CHECK(powered_down_flag, 1'h0)
        end
        $display("test halt mode table done");
        // pin wake: a disabled pin falls first and must be ignored
        write_scc(8'h03);
        porta_wake_enable = 8'h04;
        halt();
        tick(1);
        halt();
        `CHECK(wdt_clear, 1'h0)
        porta_pin = 8'hFE;
        expect_asleep(6);
        porta_pin = 8'hFA;
        wait_resume(20);
        `CHECK(resume_out.vector, 1'h0)
        `CHECK(resume_out.pc_sp_reset, 1'h0)
        `CHECK(watchdog_expiry_flag, 1'h0)
        porta_pin = 8'hFF;
        $display("test pin wake done");
        // a request already pending at halt is no wake source, a fresh one is
        irq_enable = 8'hFF;
        irq_req = 8'h02;
        tick(1);
        halt();
        expect_asleep(6);
        irq_req = 8'h0A;
        wait_resume(20);
        `CHECK(resume_out.vector, 1'h1)
        irq_req = 8'h00;
        for (int k = 0; k < 2; k++) begin
            irq_enable = (k == 1) ? 8'h20 : 8'h00;
            stack_full = (k == 1);
            tick(1);
            halt();
            irq_req = 8'h20;
            wait_resume(20);
            `CHECK(resume_out.vector, 1'h0)
            irq_req = 8'h00;
        end
        stack_full = 1'h0;
        $display("test interrupt wake done");
        complete_run();
    end
endmodule
`default_nettype wire
